// ---- src/irl_defs.vh ----
`ifndef IRL_DEFS_VH
`define IRL_DEFS_VH
`define IRL_DEV_ADDR 7'h00
`define IRL_DIR_WRITE 1'b0
`define IRL_DIR_READ 1'b1
`define IRL_REG_SLEEP 8'h20
`define IRL_SLEEP_BIT 0
`define IRL_SLEEP_RESET 1'b0
`define IRL_REG_UNLOCK 8'h24
`define IRL_REG_SHADOW0 8'h0c
`define IRL_EE_ROW_FIRST 8'h03
`define IRL_EE_ROW_LAST 8'h07
`define IRL_EE_ROWS 8
`define IRL_EE_ECC_BITS 6
`define IRL_BYTE_BITS 8
`define IRL_WORD_BYTES 3'd4
`define IRL_CMD_WRITE 1'b0
`define IRL_CMD_READ 1'b1
`define IRL_LOW_NS 1300
`define IRL_HIGH_NS 600
`define IRL_CLK_MHZ 40
`define IRL_QTR_CYC ((`IRL_LOW_NS * `IRL_CLK_MHZ + 999) / 1000 / 2 + 1)
`define IRL_DIV_W 8
`define IRL_HOLD_TICKS 8'h14
`endif

// ---- src/irl_host.v ----
// Overview of operation
// - Start is data falling while clock high; we generate it to begin.
// - Stop is data rising while clock high; we generate it to end.
// - First byte after start is seven-bit target address plus direction, then acknowledge.
// - Every data phase moves eight bits then one acknowledge bit.
// - Data changes only while clock low, stable while clock high.
// - Direction bit zero means write, one means read.
// - Controller releases data before the ninth clock for acknowledge, except after read bytes one to three, where it pulls data low itself.
// - Write: start, address+0, register byte, data bytes, stop.
// - Access mode entered by writing the fixed key to register 0x24.
// - Read: start, address+0, register byte, restart, address+1, data.
// - Controller ends a read with not-acknowledge then stop.
module irl_host (
    // Clock, reset, enable
    input wire mclk_i,
    input wire rstn_i,
    input wire ce_i,
    // Command port
    input wire cmd_valid_i,
    output wire cmd_ready_o,
    input wire cmd_rw_i,
    input wire [7:0] cmd_reg_i,
    input wire [31:0] cmd_wdata_i,
    output reg done_o,
    output reg nack_o,
    output reg [31:0] rdata_o,
    // Two-wire pins
    input wire scl_i,
    output reg scl_o,
    output reg scl_oe_o,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o
);
    `include "irl_defs.vh"

    localparam ST_IDLE = 4'd0;
    localparam ST_START = 4'd1;
    localparam ST_BIT = 4'd2;
    localparam ST_ACK = 4'd3;
    localparam ST_NEXT = 4'd4;
    localparam ST_RSTART = 4'd5;
    localparam ST_STOP = 4'd6;
    localparam ST_DONE = 4'd7;

    localparam PH_ADDRW = 3'd0;
    localparam PH_REG = 3'd1;
    localparam PH_WDATA = 3'd2;
    localparam PH_ADDRR = 3'd3;
    localparam PH_RDATA = 3'd4;

    reg [3:0] state;
    reg [2:0] phase;
    reg [1:0] quarter;
    reg [`IRL_DIV_W-1:0] div;
    reg [3:0] bitn;
    reg [2:0] bytes;
    reg [7:0] shreg;
    reg [31:0] word;
    reg rw;
    reg [7:0] regaddr;
    reg sda_s1, sda_s2, scl_s1, scl_s2;
    reg [7:0] rxbyte;
    reg [`IRL_DIV_W-1:0] stalls;

    // Quarter reload, cut to the divider's width on purpose
    localparam [31:0] QTR_FULL = `IRL_QTR_CYC;
    localparam [`IRL_DIV_W-1:0] QTR_LOAD = QTR_FULL[`IRL_DIV_W-1:0];

    wire tick = (div == 8'd0);
    assign cmd_ready_o = (state == ST_IDLE);

    // The sample quarter waits while the device holds the clock low
    wire stall = (quarter == 2'd2) && !scl_s2;

    // Step to the next quarter, or stay put while stalled
    function [1:0] next_quarter;
        input [1:0] q;
        input hold;
        begin
            next_quarter = hold ? q : q + 2'd1;
        end
    endfunction

    // Target address byte with its direction in the low bit
    function [7:0] addr_byte;
        input dir;
        begin
            addr_byte = {`IRL_DEV_ADDR, dir};
        end
    endfunction

    // Pins are sampled twice before use; the bus may be stretched by the device
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
        end else if (ce_i) begin
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
        end
    end

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
            phase <= PH_ADDRW;
            quarter <= 2'd0;
            div <= 8'd0;
            bitn <= 4'd0;
            bytes <= 3'd0;
            shreg <= 8'h00;
            word <= 32'h0;
            rw <= 1'b0;
            regaddr <= 8'h00;
            rxbyte <= 8'h00;
            stalls <= 8'h00;
            done_o <= 1'b0;
            nack_o <= 1'b0;
            rdata_o <= 32'h0;
            scl_o <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            if (state != ST_IDLE)
                div <= tick ? QTR_LOAD : div - 8'd1;
            case (state)
                ST_IDLE: begin
                    scl_oe_o <= 1'b0;
                    sda_oe_o <= 1'b0;
                    if (cmd_valid_i) begin
                        rw <= cmd_rw_i;
                        regaddr <= cmd_reg_i;
                        word <= cmd_wdata_i;
                        nack_o <= 1'b0;
                        quarter <= 2'd0;
                        div <= QTR_LOAD;
                        state <= ST_START;
                    end
                end
                ST_START, ST_RSTART: if (tick) begin
                    // Quarters: release data, release clock, pull data, pull clock
                    quarter <= next_quarter(quarter, stall);
                    case (quarter)
                        2'd0: begin
                            sda_oe_o <= 1'b0;
                        end
                        2'd1: begin
                            scl_oe_o <= 1'b0;
                        end
                        2'd2: begin
                            // A falling data line counts as start only while the clock reads high
                            if (scl_s2)
                                sda_oe_o <= 1'b1;
                        end
                        default: begin
                            scl_oe_o <= 1'b1;
                            shreg <= addr_byte(state == ST_RSTART);
                            phase <= (state == ST_RSTART) ? PH_ADDRR : PH_ADDRW;
                            bitn <= 4'd0;
                            state <= ST_BIT;
                        end
                    endcase
                end
                ST_BIT, ST_ACK: if (tick) begin
                    quarter <= next_quarter(quarter, stall);
                    case (quarter)
                        2'd0: begin
                            // Data moves only in the low half of the clock
                            if (state == ST_ACK) begin
                                sda_oe_o <= (phase == PH_RDATA) ? (bytes != `IRL_WORD_BYTES) : 1'b0;
                            end else begin
                                sda_oe_o <= (phase == PH_RDATA) ? 1'b0 : ~shreg[7];
                            end
                        end
                        2'd1: begin
                            scl_oe_o <= 1'b0;
                        end
                        2'd2: begin
                            // Wait for the clock to read high in case it is held low
                            if (!scl_s2) quarter <= quarter;
                            else if (state == ST_ACK && phase != PH_RDATA)
                                nack_o <= nack_o | sda_s2;
                            else if (state == ST_BIT)
                                rxbyte <= {rxbyte[6:0], sda_s2};
                        end
                        default: begin
                            scl_oe_o <= 1'b1;
                            if (state == ST_BIT) begin
                                shreg <= {shreg[6:0], 1'b0};
                                bitn <= bitn + 4'd1;
                                if (bitn == 4'd7)
                                    state <= ST_ACK;
                            end else begin
                                state <= ST_NEXT;
                            end
                        end
                    endcase
                end
                ST_NEXT: begin
                    bitn <= 4'd0;
                    quarter <= 2'd0;
                    state <= ST_BIT;
                    if (nack_o) begin
                        state <= ST_STOP;
                    end else case (phase)
                        PH_ADDRW: begin
                            phase <= PH_REG;
                            shreg <= regaddr;
                        end
                        PH_REG: begin
                            bytes <= 3'd0;
                            if (rw == `IRL_CMD_READ)
                                state <= ST_RSTART;
                            else begin
                                phase <= PH_WDATA;
                                shreg <= word[31:24];
                                bytes <= 3'd1;
                            end
                        end
                        PH_WDATA: begin
                            if (bytes == `IRL_WORD_BYTES)
                                state <= ST_STOP;
                            else begin
                                shreg <= word[23:16];
                                word <= {word[23:0], 8'h00};
                                bytes <= bytes + 3'd1;
                            end
                        end
                        PH_ADDRR: begin
                            phase <= PH_RDATA;
                            bytes <= 3'd1;
                        end
                        default: begin
                            // Collect MSB first; the fourth byte was answered with NACK
                            word <= {word[23:0], rxbyte};
                            if (bytes == `IRL_WORD_BYTES)
                                state <= ST_STOP;
                            else
                                bytes <= bytes + 3'd1;
                        end
                    endcase
                end
                ST_STOP: if (tick) begin
                    quarter <= next_quarter(quarter, stall);
                    case (quarter)
                        2'd0: begin
                            sda_oe_o <= 1'b1;
                        end
                        2'd1: begin
                            scl_oe_o <= 1'b0;
                        end
                        2'd2: begin
                            if (scl_s2)
                                sda_oe_o <= 1'b0;
                        end
                        default: begin
                            state <= ST_DONE;
                        end
                    endcase
                end
                ST_DONE: begin
                    if (rw == `IRL_CMD_READ && !nack_o)
                        rdata_o <= word;
                    done_o <= 1'b1;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            // A clock held low too long must not hang the port; give up and report a refusal
            if (state != ST_IDLE && tick) begin
                if (!stall)
                    stalls <= 8'h00;
                else if (stalls == `IRL_HOLD_TICKS) begin
                    stalls <= 8'h00;
                    nack_o <= 1'b1;
                    scl_oe_o <= 1'b0;
                    sda_oe_o <= 1'b0;
                    quarter <= 2'd0;
                    state <= ST_DONE;
                end else
                    stalls <= stalls + 8'h01;
            end
        end
    end
endmodule // irl_host

// ---- test/irl_host_monitor.sv ----
module irl_host_monitor (
    // Clock and reset
    input wire mclk_i,
    input wire rstn_i,
    // Command side
    input wire ce_i,
    input wire cmd_valid_i,
    input wire cmd_ready_o,
    input wire cmd_rw_i,
    input wire done_o,
    input wire nack_o,
    input wire [31:0] rdata_o,
    // Pins
    input wire scl_o,
    input wire scl_oe_o,
    input wire sda_o,
    input wire sda_oe_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    logic take;
    logic rw;
    logic [7:0] lows;
    assign take = cmd_valid_i && cmd_ready_o && ce_i;
    // Clock low pulses since the request; a wrong bit count per byte shows here
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rw <= 1'b0;
            lows <= 8'h00;
        end else if (take) begin
            rw <= cmd_rw_i;
            lows <= 8'h00;
        end else if ($rose(scl_oe_o)) begin
            lows <= lows + 8'h01;
        end
    end
    property p_open_drain; !scl_o && !sda_o; endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    property p_idle_free; cmd_ready_o |-> !scl_oe_o && !sda_oe_o; endproperty
    a_idle_free: assert property (p_idle_free) else $error("bus held while idle");
    property p_take_busy; take |=> !cmd_ready_o; endproperty
    a_take_busy: assert property (p_take_busy) else $error("request not taken");
    property p_start; take |-> ##[1:300] ($rose(sda_oe_o) && !scl_oe_o); endproperty
    a_start: assert property (p_start) else $error("no start after request");
    property p_stop; $fell(sda_oe_o) && !scl_oe_o && !$past(scl_oe_o) |-> ##[1:100] done_o; endproperty
    a_stop: assert property (p_stop) else $error("no completion after stop");
    property p_done_pulse; done_o |=> !done_o; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
    property p_count; done_o && !nack_o |-> lows == (rw ? 8'd65 : 8'd55); endproperty
    a_count: assert property (p_count) else $error("wrong clock pulse count");
    property p_rdata_moves; !$stable(rdata_o) |-> done_o && rw; endproperty
    a_rdata_moves: assert property (p_rdata_moves) else $error("read word moved");
    property p_released; done_o |-> !sda_oe_o && !scl_oe_o; endproperty
    a_released: assert property (p_released) else $error("bus held at done");
    c_write: cover property (take && !cmd_rw_i);
    c_read: cover property (take && cmd_rw_i);
    c_nack: cover property (done_o && nack_o);
endmodule // irl_host_monitor

bind irl_host irl_host_monitor i_irl_host_monitor (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_rw_i(cmd_rw_i), .done_o(done_o),
    .nack_o(nack_o), .rdata_o(rdata_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

// ---- test/irl_dev_model.sv ----
module irl_dev_model #(
    parameter logic [31:0] ACCESS_KEY = 32'h5eedc0de // Arbitrary value
) (
    // Bus lines
    input wire scl_i,
    input wire sda_i,
    output logic sda_oe_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] mem [0:255];
    logic [31:0] wd;
    logic [7:0] sh, ptr;
    logic [3:0] bc;
    logic [1:0] ph, bi;
    logic act, mack, drv, unlk;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = {4{i[7:0]}};
        mem[8'h20] = 32'h0;
        // Rows 3..7 copied to 0x0c..0x10; top six bits stand for check bits
        for (int r = 3; r < 8; r++) mem[r + 9] = {6'h15, 26'habcd00 + 26'(r)};
        {act, drv, unlk, sda_oe_o, bc, ph, bi} = '0;
    end
    always @(negedge sda_i) if (scl_i) begin
        act = 1;
        drv = 0;
        ph = 0;
        bc = 0;
        sda_oe_o = 0;
    end
    always @(posedge sda_i) if (scl_i) act = 0;
    always @(posedge scl_i) if (act) begin
        if (bc < 8) sh = {sh[6:0], sda_i};
        else mack = !sda_i;
        bc = bc + 1;
    end
    always @(negedge scl_i) if (act) begin
        sda_oe_o = 0;
        if (bc == 9) begin
            bc = 0;
            drv = mack && ph == 3;
        end else if (bc == 8 && ph == 0) begin
            act = sh[7:1] == 7'h00;
            sda_oe_o = act;
            ph = sh[0] ? 2'd3 : 2'd1;
        end else if (bc == 8 && ph == 1) begin
            ptr = sh;
            bi = 0;
            ph = 2;
            sda_oe_o = 1;
        end else if (bc == 8 && ph == 2) begin
            wd = {wd[23:0], sh};
            sda_oe_o = 1;
            bi = bi + 1;
            if (bi == 0) begin
                if (unlk || ptr == 8'h20) mem[ptr] = ptr == 8'h20 ? {31'h0, wd[0]} : wd;
                if (ptr == 8'h24 && wd == ACCESS_KEY) unlk = 1;
                ptr = ptr + 1;
            end
        end else if (bc == 8) begin
            bi = bi + 1;
            if (bi == 0) ptr = ptr + 1;
        end
        if (act && ph == 3 && drv && bc < 8) sda_oe_o = !mem[ptr][31 - 8 * bi - bc];
    end
endmodule // irl_dev_model

// ---- test/tb_irl_host.sv ----
module tb_irl_host;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] KEY = 32'h5eedc0de; // Arbitrary value
    typedef struct {logic rw; logic [7:0] ra; logic [31:0] wd; logic [31:0] rd;} irl_row_t;
    logic mclk_i = 0, rstn_i = 0, cmd_valid = 0, cmd_rw = 0, mute = 0, ce = 1, hold = 0;
    logic [1:0] held = 0;
    logic [7:0] cmd_reg = 0;
    logic [31:0] cmd_wdata = 0;
    wire cmd_ready, done, nack, scl_oe, sda_oe, dev_oe, scl_o, sda_o;
    wire [31:0] rdata;
    // Pull-ups on both lines
    wire scl = !scl_oe && !hold;
    wire sda = !(sda_oe || (dev_oe && !mute));
    int bad_count = 0, checks_done = 0;
    irl_row_t rows [9] = '{'{1, 8'h20, 0, 0}, '{1, 8'h0c, 0, {6'h15, 26'habcd03}},
        '{0, 8'h30, 32'h11223344, 0}, '{1, 8'h30, 0, 32'h30303030}, '{0, 8'h20, 32'h3, 0},
        '{1, 8'h20, 0, 32'h1}, '{0, 8'h24, KEY, 0}, '{0, 8'h0c, 32'hcafef00d, 0},
        '{1, 8'h0c, 0, 32'hcafef00d}};
    irl_host i_irl_host (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce), .cmd_valid_i(cmd_valid),
        .cmd_ready_o(cmd_ready), .cmd_rw_i(cmd_rw), .cmd_reg_i(cmd_reg), .cmd_wdata_i(cmd_wdata),
        .done_o(done), .nack_o(nack), .rdata_o(rdata), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe));
    irl_dev_model #(.ACCESS_KEY(KEY)) i_irl_dev_model (.scl_i(scl), .sda_i(sda), .sda_oe_o(dev_oe));
    always #12.5 mclk_i = ~mclk_i;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic run(input irl_row_t r, input logic en, input logic wait_done);
        int n;
        for (n = 0; n < 100 && cmd_ready !== 1'b1; n++) @(posedge mclk_i) #2;
        if (n == 100) begin
            bad_count++;
            report_and_stop();
        end
        cmd_rw = r.rw;
        cmd_reg = r.ra;
        cmd_wdata = r.wd;
        cmd_valid = 1;
        @(posedge mclk_i) #2 cmd_valid = 0;
        // A bus transfer is several thousand cycles long
        for (n = 0; n < 12000 && wait_done && done !== 1'b1; n++) @(posedge mclk_i) #2;
        if (n == 12000) begin
            bad_count++;
            report_and_stop();
        end
        if (wait_done) check({31'h0, nack}, {31'h0, en});
        if (wait_done && r.rw && !en) check(rdata, r.rd);
    endtask
    initial begin
        repeat (4) @(posedge mclk_i);
        #2 rstn_i = 1;
        check({30'h0, scl_oe, sda_oe}, 32'h0);
        foreach (rows[i]) begin
            run(rows[i], 0, 1);
            $display("row %0d done", i);
        end
        mute = 1;
        run('{0, 8'h30, 0, 0}, 1, 1);
        mute = 0;
        $display("absent device test done");
        // The device holds the clock low: the port must give up with a refusal
        run('{0, 8'h30, 0, 0}, 0, 0);
        repeat (300) @(posedge mclk_i);
        #2 hold = 1;
        for (int n = 0; n < 2000 && done !== 1'b1; n++) @(posedge mclk_i) #2;
        if (done !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
        check({31'h0, nack}, 32'h1);
        hold = 0;
        $display("held clock test done");
        // Freeze the port mid-transfer, then reset it while the register byte goes out
        run('{1, 8'h10, 0, 0}, 0, 0);
        repeat (600) @(posedge mclk_i);
        #2 ce = 0;
        held = {scl_oe, sda_oe};
        repeat (300) @(posedge mclk_i);
        #2 check({30'h0, scl_oe, sda_oe}, {30'h0, held});
        ce = 1;
        repeat (600) @(posedge mclk_i);
        #2 rstn_i = 0;
        @(posedge mclk_i) #2 rstn_i = 1;
        run('{1, 8'h10, 0, {6'h15, 26'habcd07}}, 0, 1);
        $display("reset abort test done");
        report_and_stop();
    end
endmodule // tb_irl_host
